// ===== logic/dl_pkg.sv
// constants, states and carriers of the debug link instruction handler
package dl_pkg;
  // instruction opcode field, bits [7:5] of the instruction byte
  localparam logic [2:0] OP_DLOAD = 3'h0;
  localparam logic [2:0] OP_ILOAD = 3'h1;
  localparam logic [2:0] OP_DSTORE = 3'h2;
  localparam logic [2:0] OP_ISTORE = 3'h3;
  localparam logic [2:0] OP_CLOAD = 3'h4;
  localparam logic [2:0] OP_REPEAT = 3'h5;
  localparam logic [2:0] OP_CSTORE = 3'h6;
  localparam logic [2:0] OP_KEY = 3'h7;
  localparam int OP_LSB = 5;
  localparam int MODE_LSB = 2;
  localparam int CSADDR_W = 4;
  // pointer modes of the indirect store and load
  localparam logic [1:0] PTR_DATA = 2'h0;
  localparam logic [1:0] PTR_INC = 2'h1;
  localparam logic [1:0] PTR_ADDR = 2'h2;
  // key and information block size codes
  localparam logic [1:0] KEY_SIZE_64 = 2'h0;
  localparam logic [1:0] KEY_SIZE_128 = 2'h1;
  localparam logic [4:0] KEY_BYTES = 5'h08;
  localparam logic [4:0] INFO_BYTES = 5'h10;
  // fixed acknowledge character
  localparam logic [7:0] ACK_BYTE = 8'h40;
  // control/status space addresses
  localparam logic [3:0] CS_STATUS = 4'h0;
  localparam logic [3:0] CS_CTRL = 4'h1;
  localparam logic [3:0] CS_CRC = 4'h2;
  localparam logic [3:0] CS_ERRSIG = 4'h3;
  // fields
  localparam int GUARD_W = 3;
  localparam logic [2:0] GUARD_RST = 3'h2;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_KEY_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_RPT_BIT = 3;
  localparam int CRC_DONE_BIT = 0;
  localparam int CRC_FAIL_BIT = 1;
  // error signatures
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_RX = 3'h1;
  localparam logic [2:0] ERR_BUS = 3'h2;
  localparam logic [2:0] ERR_OP = 3'h3;
  localparam logic [2:0] ERR_LOCK = 3'h4;

  typedef enum logic [3:0] {
    S_SYNC, S_INSTR, S_EXEC, S_OPER, S_APPLY, S_BUSY, S_GUARD, S_SEND, S_NEXT, S_ERR
  } dl_state_t;

  // received character from the serial layer
  typedef struct packed {
    logic sync;
    logic brk;
    logic err;
    logic valid;
    logic [7:0] data;
  } dl_rx_t;

  // system bus request
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dl_bus_req_t;

  // system bus answer
  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } dl_bus_rsp_t;
endpackage : dl_pkg

// ===== logic/dl_handler.sv
// debug link instruction handler: decode, operands, bus access, responses
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Function
// [RULE1] pointer-mode 2 store loads pointer from address bytes, then acknowledges
// [RULE2] pointer-mode 0 store writes data at pointer, pointer unchanged
// [RULE3] pointer-mode 1 store advances pointer by data size after write
// [RULE4] data bytes follow store; acknowledge only after successful bus write
// [RULE5] address and data operands up to 32 bits
// [RULE6] every repeated store frame is acknowledged before the next
// [RULE7] control load reads one byte of internal space at operand address; the code takes the address from instruction bits [3:0], no operand byte
// [RULE8] control load byte is sent after the guard interval
// [RULE9] control store takes one byte, writes whole byte to addressed register; the code keeps only bits [2:0], and only at CS_CTRL
// [RULE10] control store sends no response
// [RULE11] repeated iterations take operand and data frames only
// [RULE12] debugger never repeats the repeat instruction
// [RULE13] repeat count up to 255, instruction runs count plus one times
// [RULE14] repeat size field sets width of the count operand
// [RULE15] only a break aborts a running repeat
// [RULE16] repeated indirect load streams, guard only before first block
// [RULE17] debugger resends full address each direct-addressed iteration
// [RULE18] key is 64 bits only; information block at most 128 bits
// [RULE19] key size sets frame count; no answer after key bytes
// [RULE20] information block is sent after the guard interval
// [RULE21] boot crc result readable in control space even when locked
// [RULE22] each received sync character emits an event pulse
// [RULE23] configurable idle bits precede the first response byte
// [RULE24] after an error all requests are ignored until a break
// [RULE25] every acknowledge uses one fixed byte constant
module dl_handler #(
  parameter logic [127:0] INFO_VALUE = 128'h0123456789ABCDEFFEDCBA9876543210 // arbitrary
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // receive side of the serial layer
  input wire dl_pkg::dl_rx_t rx,
  input wire logic bit_tick,
  // transmit side of the serial layer
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // system bus
  output dl_pkg::dl_bus_req_t bus_req,
  input wire dl_pkg::dl_bus_rsp_t bus_rsp,
  // device status and key output
  input wire logic sys_locked,
  input wire logic boot_crc_done,
  input wire logic boot_crc_fail,
  output logic [63:0] key_data,
  output logic key_strobe,
  output logic sync_evt,
  // software register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  dl_pkg::dl_state_t state;
  logic [2:0] op;
  logic [1:0] mode;
  logic [1:0] size;
  logic [3:0] cs_addr;
  logic [63:0] opnd;
  logic [3:0] cnt;
  logic [4:0] need;
  logic [31:0] ptr;
  logic [7:0] rpt_cnt;
  logic [7:0] rpt_left;
  logic rpt_pend;
  logic first;
  logic [127:0] tx_buf;
  logic [4:0] tx_left;
  logic [2:0] errsig;
  logic key_valid;
  logic cs_we;
  logic [7:0] cs_wdata;
  logic [dl_pkg::GUARD_W-1:0] guard_bits;
  logic [dl_pkg::GUARD_W-1:0] guard_cnt;
  logic [1:0] crc_stat;

  // control/status space read view, never gated by the lock
  function automatic logic [7:0] cs_read(input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      dl_pkg::CS_STATUS: begin
        v[dl_pkg::STAT_ERR_BIT] = (state == dl_pkg::S_ERR);
        v[dl_pkg::STAT_KEY_BIT] = key_valid;
        v[dl_pkg::STAT_LOCK_BIT] = sys_locked;
        v[dl_pkg::STAT_RPT_BIT] = (rpt_left != 8'h00) | rpt_pend;
      end
      dl_pkg::CS_CTRL: v[dl_pkg::GUARD_W-1:0] = guard_bits;
      dl_pkg::CS_CRC: v[1:0] = crc_stat; // [RULE21]
      dl_pkg::CS_ERRSIG: v[2:0] = errsig;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : cs_read

  // operand bytes expected by the current instruction
  always_comb begin
    unique case (op)
      dl_pkg::OP_CSTORE: need = 5'h01; // [RULE9]
      dl_pkg::OP_KEY: need = dl_pkg::KEY_BYTES; // [RULE18] [RULE19]
      default: need = {3'h0, size} + 5'h01; // [RULE5] [RULE14]
    endcase
  end

  // instruction sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= dl_pkg::S_SYNC;
      op <= dl_pkg::OP_DLOAD;
      mode <= dl_pkg::PTR_DATA;
      size <= 2'h0;
      cs_addr <= 4'h0;
      opnd <= 64'h0;
      cnt <= 4'h0;
      ptr <= 32'h0;
      rpt_cnt <= 8'h00;
      rpt_left <= 8'h00;
      rpt_pend <= 1'b0;
      first <= 1'b0;
      tx_buf <= 128'h0;
      tx_left <= 5'h00;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      bus_req <= '0;
      errsig <= dl_pkg::ERR_NONE;
      key_data <= 64'h0;
      key_strobe <= 1'b0;
      key_valid <= 1'b0;
      cs_we <= 1'b0;
      cs_wdata <= 8'h00;
    end else begin
      key_strobe <= 1'b0;
      cs_we <= 1'b0;
      if (rx.brk) begin
        // break is the only way out of an error or a running repeat
        state <= dl_pkg::S_SYNC; // [RULE15] [RULE24]
        rpt_left <= 8'h00;
        rpt_pend <= 1'b0;
        tx_valid <= 1'b0;
        bus_req.req <= 1'b0;
      end else if (rx.err && state != dl_pkg::S_ERR) begin
        state <= dl_pkg::S_ERR; // [RULE24]
        errsig <= dl_pkg::ERR_RX;
        tx_valid <= 1'b0;
        bus_req.req <= 1'b0;
      end else begin
        unique case (state)
          dl_pkg::S_SYNC: begin
            if (rx.sync) begin
              state <= dl_pkg::S_INSTR;
            end
          end
          dl_pkg::S_INSTR: begin
            if (rx.valid) begin
              op <= rx.data[7:dl_pkg::OP_LSB];
              mode <= rx.data[dl_pkg::MODE_LSB+1:dl_pkg::MODE_LSB];
              size <= rx.data[1:0];
              cs_addr <= rx.data[dl_pkg::CSADDR_W-1:0];
              // a pending count applies to this instruction only
              rpt_left <= rpt_pend ? rpt_cnt : 8'h00; // [RULE13]
              rpt_pend <= 1'b0;
              first <= 1'b1;
              state <= dl_pkg::S_EXEC;
            end
          end
          dl_pkg::S_EXEC: begin
            cnt <= 4'h0;
            opnd <= 64'h0;
            unique case (op)
              dl_pkg::OP_ISTORE, dl_pkg::OP_CSTORE, dl_pkg::OP_REPEAT: state <= dl_pkg::S_OPER;
              dl_pkg::OP_ILOAD: begin
                if (sys_locked) begin
                  state <= dl_pkg::S_ERR;
                  errsig <= dl_pkg::ERR_LOCK;
                end else begin
                  bus_req <= {1'b1, 1'b0, size, ptr, 32'h0};
                  state <= dl_pkg::S_BUSY;
                end
              end
              dl_pkg::OP_CLOAD: begin
                tx_buf <= {120'h0, cs_read(cs_addr)}; // [RULE7]
                tx_left <= 5'h01;
                state <= dl_pkg::S_GUARD; // [RULE8]
              end
              dl_pkg::OP_KEY: begin
                if (mode[0] && size == dl_pkg::KEY_SIZE_128) begin
                  tx_buf <= INFO_VALUE;
                  tx_left <= dl_pkg::INFO_BYTES; // [RULE18] [RULE19]
                  state <= dl_pkg::S_GUARD; // [RULE20]
                end else if (mode[0] && size == dl_pkg::KEY_SIZE_64) begin
                  tx_buf <= INFO_VALUE;
                  tx_left <= dl_pkg::KEY_BYTES; // [RULE19]
                  state <= dl_pkg::S_GUARD; // [RULE20]
                end else if (size == dl_pkg::KEY_SIZE_64) begin
                  state <= dl_pkg::S_OPER;
                end else begin
                  state <= dl_pkg::S_ERR; // [RULE18]
                  errsig <= dl_pkg::ERR_OP;
                end
              end
              default: begin
                // direct-addressed access is not handled by this block
                state <= dl_pkg::S_ERR;
                errsig <= dl_pkg::ERR_OP;
              end
            endcase
          end
          dl_pkg::S_OPER: begin
            if (rx.valid) begin
              opnd[cnt[2:0]*8 +: 8] <= rx.data; // [RULE4] [RULE9]
              cnt <= cnt + 4'h1;
              if ({1'b0, cnt} == need - 5'h01) begin
                state <= dl_pkg::S_APPLY;
              end
            end
          end
          dl_pkg::S_APPLY: begin
            unique case (op)
              dl_pkg::OP_ISTORE: begin
                if (mode == dl_pkg::PTR_ADDR) begin
                  ptr <= opnd[31:0]; // [RULE1]
                  tx_buf <= {120'h0, dl_pkg::ACK_BYTE}; // [RULE25]
                  tx_left <= 5'h01;
                  state <= dl_pkg::S_GUARD;
                end else if (sys_locked) begin
                  state <= dl_pkg::S_ERR;
                  errsig <= dl_pkg::ERR_LOCK;
                end else begin
                  bus_req <= {1'b1, 1'b1, size, ptr, opnd[31:0]}; // [RULE2]
                  state <= dl_pkg::S_BUSY;
                end
              end
              dl_pkg::OP_CSTORE: begin
                cs_we <= 1'b1; // [RULE9]
                cs_wdata <= opnd[7:0];
                state <= dl_pkg::S_NEXT; // [RULE10]
              end
              dl_pkg::OP_REPEAT: begin
                rpt_cnt <= opnd[7:0]; // [RULE13] [RULE14]
                rpt_pend <= 1'b1;
                state <= dl_pkg::S_NEXT;
              end
              default: begin
                key_data <= opnd; // [RULE18]
                key_strobe <= 1'b1;
                key_valid <= 1'b1;
                state <= dl_pkg::S_NEXT; // [RULE19]
              end
            endcase
          end
          dl_pkg::S_BUSY: begin
            if (bus_rsp.done) begin
              bus_req.req <= 1'b0;
              if (bus_rsp.err) begin
                state <= dl_pkg::S_ERR; // [RULE24]
                errsig <= dl_pkg::ERR_BUS;
              end else begin
                if (mode == dl_pkg::PTR_INC) begin
                  ptr <= ptr + {30'h0, size} + 32'h1; // [RULE3]
                end
                if (op == dl_pkg::OP_ISTORE) begin
                  tx_buf <= {120'h0, dl_pkg::ACK_BYTE}; // [RULE4] [RULE25]
                  tx_left <= 5'h01;
                  state <= dl_pkg::S_GUARD; // [RULE6]
                end else begin
                  tx_buf <= {96'h0, bus_rsp.rdata};
                  tx_left <= {3'h0, size} + 5'h01;
                  // later blocks of a repeated load follow with no idle gap
                  state <= first ? dl_pkg::S_GUARD : dl_pkg::S_SEND; // [RULE16]
                end
              end
            end
          end
          dl_pkg::S_GUARD: begin
            if (guard_cnt == guard_bits) begin
              state <= dl_pkg::S_SEND; // [RULE23]
            end
          end
          dl_pkg::S_SEND: begin
            // bytes go out least significant first, back to back
            if (!tx_valid) begin
              tx_valid <= 1'b1;
              tx_data <= tx_buf[7:0];
              tx_buf <= tx_buf >> 8;
            end else if (tx_ready) begin
              if (tx_left == 5'h01) begin
                tx_valid <= 1'b0;
                state <= dl_pkg::S_NEXT;
              end else begin
                tx_data <= tx_buf[7:0];
                tx_buf <= tx_buf >> 8;
              end
              tx_left <= tx_left - 5'h01;
            end
          end
          dl_pkg::S_NEXT: begin
            first <= 1'b0;
            if (rpt_left != 8'h00) begin
              rpt_left <= rpt_left - 8'h01;
              state <= dl_pkg::S_EXEC; // [RULE11]
            end else begin
              state <= dl_pkg::S_SYNC;
            end
          end
          dl_pkg::S_ERR: state <= dl_pkg::S_ERR; // [RULE24]
          default: state <= dl_pkg::S_ERR;
        endcase
      end
    end
  end

  // guard idle bits, counted in bit periods of the current baud
  always_ff @(posedge mclk) begin
    if (rst || state != dl_pkg::S_GUARD) begin
      guard_cnt <= '0;
    end else if (bit_tick && guard_cnt != guard_bits) begin
      guard_cnt <= guard_cnt + 3'h1; // [RULE23]
    end
  end

  // guard setting; software wins a collision with a debugger store
  always_ff @(posedge mclk) begin
    if (rst) begin
      guard_bits <= dl_pkg::GUARD_RST;
    end else if (reg_wr && reg_addr == dl_pkg::CS_CTRL) begin
      guard_bits <= reg_wdata[dl_pkg::GUARD_W-1:0];
    end else if (cs_we && cs_addr == dl_pkg::CS_CTRL) begin
      guard_bits <= cs_wdata[dl_pkg::GUARD_W-1:0]; // [RULE9]
    end
  end

  // boot crc result, captured independently of the lock
  always_ff @(posedge mclk) begin
    if (rst) begin
      crc_stat <= 2'h0;
    end else if (boot_crc_done) begin
      crc_stat[dl_pkg::CRC_DONE_BIT] <= 1'b1; // [RULE21]
      crc_stat[dl_pkg::CRC_FAIL_BIT] <= boot_crc_fail;
    end
  end

  // sync event for a capture timer, one pulse per sync character
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_evt <= 1'b0;
    end else begin
      sync_evt <= rx.sync; // [RULE22]
    end
  end

  // software read port, data valid only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? cs_read(reg_addr) : 8'h00;
    end
  end
endmodule : dl_handler

// ===== tb/dl_handler_props.sv
// assertion checker for the debug link instruction handler
`timescale 1ns/1ps
module dl_handler_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link side
  input wire dl_pkg::dl_rx_t rx,
  input wire logic bit_tick,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  // system bus
  input wire dl_pkg::dl_bus_req_t bus_req,
  input wire dl_pkg::dl_bus_rsp_t bus_rsp,
  // status and software port
  input wire logic key_strobe,
  input wire logic sync_evt,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_SYNC_EVT:
    assert property (rx.sync |=> sync_evt) else $error("sync event missing");
  AST_SYNC_CAUSE:
    assert property (sync_evt |-> $past(rx.sync)) else $error("sync event without sync");
  // a break or a receive error legally drops an offered byte or a bus request
  AST_TX_HOLD:
    assert property (tx_valid && !tx_ready && !rx.brk && !rx.err |=>
      tx_valid && $stable(tx_data)) else $error("answer byte not held");
  AST_BUS_HOLD:
    assert property (bus_req.req && !bus_rsp.done && !rx.brk && !rx.err |=>
      bus_req.req && $stable(bus_req.addr)) else $error("bus request not held");
  AST_BUS_DROP:
    assert property (bus_rsp.done |=> !bus_req.req) else $error("bus request after done");
  AST_ERR_QUIET:
    assert property (bus_rsp.done && bus_rsp.err |=> (!tx_valid) [*8])
      else $error("answer after failed access");
  AST_KEY_PULSE:
    assert property (key_strobe |=> !key_strobe) else $error("key strobe too long");
  AST_RDATA_IDLE:
    assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data outside read");
  // the tick that completes the guard count leads the first byte by three cycles
  AST_GUARD_TICK:
    assert property ($rose(tx_valid) |-> $past(bit_tick, 3)) else $error("answer off bit period");
  AST_CTRL_RW:
    assert property (reg_wr && reg_addr == dl_pkg::CS_CTRL ##1
      reg_rd && reg_addr == dl_pkg::CS_CTRL |=> reg_rdata == $past(reg_wdata, 2))
      else $error("guard setting not kept");
endmodule : dl_handler_props

bind dl_handler dl_handler_props u_props (.mclk(mclk), .rst(rst), .rx(rx), .bit_tick(bit_tick),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .bus_req(bus_req),
  .bus_rsp(bus_rsp), .key_strobe(key_strobe), .sync_evt(sync_evt), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ===== tb/dl_far_model.sv
// far side model: bus target, byte sink of the serial layer, baud tick
`timescale 1ns/1ps
module dl_far_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // system bus
  input wire dl_pkg::dl_bus_req_t bus_req,
  output dl_pkg::dl_bus_rsp_t bus_rsp,
  input wire logic fail,
  // serial layer
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic bit_tick
);
  logic [7:0] q[$];
  logic [31:0] wa = 32'h0;
  logic [31:0] wd = 32'h0;
  int div = 0;
  int wait_c = 0;
  int slow = 0;
  int hold = 0;
  initial begin
    bus_rsp = '0;
    tx_ready = 1'b0;
    bit_tick = 1'b0;
  end
  // one bit period every four clocks
  always @(posedge mclk) begin
    div <= rst ? 0 : div + 1;
    bit_tick <= div[1:0] == 2'h3;
  end
  // answers alternate prompt and slow; idle data toggles so stale values never match
  always @(posedge mclk) begin
    bus_rsp.done <= 1'b0;
    bus_rsp.err <= 1'b0;
    bus_rsp.rdata <= ~bus_rsp.rdata;
    if (bus_req.req && !bus_rsp.done) begin
      wait_c <= wait_c + 1;
      if (wait_c >= slow * 5) begin
        bus_rsp.done <= 1'b1;
        bus_rsp.err <= fail;
        wait_c <= 0;
        slow <= 1 - slow;
        if (bus_req.we) begin
          wa <= bus_req.addr;
          wd <= bus_req.wdata;
        end
      end
    end
  end
  // take each byte two cycles late so the handler has to hold it
  always @(posedge mclk) begin
    tx_ready <= 1'b0;
    if (tx_valid && !tx_ready) begin
      hold <= hold + 1;
      if (hold == 1) begin
        tx_ready <= 1'b1;
        q.push_back(tx_data);
        hold <= 0;
      end
    end
  end
endmodule : dl_far_model

// ===== tb/tb_dl_handler.sv
// self-checking bench of the debug link instruction handler
`timescale 1ns/1ps
module tb_dl_handler;
  localparam logic [127:0] INFO = 128'h00112233445566778899AABBCCDDEEF1; // arbitrary
  localparam logic [63:0] KEY = 64'h0F1E2D3C4B5A6978;
  localparam logic [31:0] BASE = 32'h20001230;
  localparam logic [3:0] V = 4'h1;
  localparam logic [3:0] B = 4'h4;
  localparam logic [3:0] S = 4'h8;
  logic mclk;
  logic rst = 1'b1;
  dl_pkg::dl_rx_t rx;
  dl_pkg::dl_bus_req_t bus_req;
  dl_pkg::dl_bus_rsp_t bus_rsp;
  logic bit_tick, tx_valid, tx_ready, key_strobe, sync_evt, fail, locked, crc_d, crc_f;
  logic reg_wr, reg_rd, tv_q;
  logic [7:0] tx_data, reg_wdata, reg_rdata;
  logic [3:0] reg_addr;
  logic [63:0] key_data;
  int errors = 0;
  int checks_done = 0;
  int ticks = 0;
  int gseen = 0;
  dl_handler #(.INFO_VALUE(INFO)) dut (.mclk(mclk), .rst(rst), .rx(rx), .bit_tick(bit_tick),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .sys_locked(locked), .boot_crc_done(crc_d), .boot_crc_fail(crc_f),
    .key_data(key_data), .key_strobe(key_strobe), .sync_evt(sync_evt), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  dl_far_model far (.mclk(mclk), .rst(rst), .bus_req(bus_req), .bus_rsp(bus_rsp), .fail(fail),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .bit_tick(bit_tick));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // bit periods from the last received byte to the start of an answer
  always @(posedge mclk) begin
    tv_q <= tx_valid;
    ticks <= rx.valid ? 0 : ticks + int'(bit_tick);
    if (tx_valid && !tv_q) gseen <= ticks;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one character; the data line shows the inverse between characters
  task automatic rxc(input logic [3:0] f, input logic [7:0] d);
    @(posedge mclk);
    rx <= {f, d};
    @(posedge mclk);
    rx <= {4'h0, ~d};
    repeat (6) @(posedge mclk);
  endtask : rxc
  task automatic txb(input string what, input logic [7:0] exp);
    for (int n = 0; n < 2000 && far.q.size() == 0; n++) @(posedge mclk);
    if (far.q.size() == 0) chk(what, 32'hX, {24'h0, exp});
    else chk(what, {24'h0, far.q.pop_front()}, {24'h0, exp});
    // the handler needs a few cycles to finish the answer before it listens again
    repeat (4) @(posedge mclk);
  endtask : txb
  task automatic rreg(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(what, {24'h0, reg_rdata}, {24'h0, exp});
  endtask : rreg
  // write immediately followed by a read of the same place
  task automatic wrrd(input string what, input logic [3:0] a, input logic [7:0] d,
                      input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    rreg(what, a, exp);
  endtask : wrrd
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  // cut a hang short well past the expected run length
  initial begin
    #100000;
    errors++;
    conclude();
  end
  initial begin
    rx = '0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, fail, locked, crc_d, crc_f} = '0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rreg("ctrl", dl_pkg::CS_CTRL, {5'h00, dl_pkg::GUARD_RST});
    rreg("unmapped", 4'hF, 8'h00);
    wrrd("crc ro", dl_pkg::CS_CRC, 8'hFF, 8'h00);
    wrrd("guard", dl_pkg::CS_CTRL, 8'h03, 8'h03);
    $display("test registers done");
    rxc(S, 8'h00);
    rxc(V, 8'h6B);
    for (int i = 0; i < 4; i++) rxc(V, BASE[8*i +: 8]);
    txb("ptr ack", dl_pkg::ACK_BYTE);
    rxc(S, 8'h00);
    rxc(V, 8'hA0);
    rxc(V, 8'h02);
    rreg("rpt on", dl_pkg::CS_STATUS, 8'h08);
    rxc(S, 8'h00);
    rxc(V, 8'h65);
    for (int k = 0; k < 3; k++) begin
      rxc(V, k[7:0]);
      rxc(V, 8'hA5);
      txb("rpt ack", dl_pkg::ACK_BYTE);
      chk("rpt addr", far.wa, BASE + 32'(2 * k));
      chk("rpt data", far.wd, {16'h0, 8'hA5, k[7:0]});
    end
    rreg("rpt off", dl_pkg::CS_STATUS, 8'h00);
    for (int k = 0; k < 2; k++) begin
      rxc(S, 8'h00);
      rxc(V, 8'h60);
      rxc(V, 8'h3C);
      txb("st ack", dl_pkg::ACK_BYTE);
      chk("st addr", far.wa, BASE + 32'h6);
    end
    $display("test stores done");
    fail <= 1'b1;
    rxc(S, 8'h00);
    rxc(V, 8'h60);
    rxc(V, 8'h11);
    rxc(S, 8'h00);
    rxc(V, 8'h82);
    repeat (80) @(posedge mclk);
    chk("ignored", far.q.size(), 0);
    rreg("sig", dl_pkg::CS_ERRSIG, {5'h00, dl_pkg::ERR_BUS});
    rxc(B, 8'h00);
    fail <= 1'b0;
    // direct store followed by one operand byte; the handler refuses the opcode
    rxc(S, 8'h00);
    rxc(V, 8'h40);
    rxc(V, 8'h10);
    rreg("direct", dl_pkg::CS_ERRSIG, {5'h00, dl_pkg::ERR_OP});
    rxc(B, 8'h00);
    rxc(S, 8'h00);
    rxc(V, 8'hA0);
    rxc(V, 8'h05);
    rxc(S, 8'h00);
    rxc(V, 8'h64);
    rxc(V, 8'h77);
    txb("abort ack", dl_pkg::ACK_BYTE);
    rxc(B, 8'h00);
    rreg("aborted", dl_pkg::CS_STATUS, 8'h00);
    $display("test error and break done");
    locked <= 1'b1;
    crc_d <= 1'b1;
    crc_f <= 1'b1;
    rxc(S, 8'h00);
    rxc(V, 8'hC1);
    rxc(V, 8'h05);
    chk("cs quiet", far.q.size(), 0);
    rreg("cs store", dl_pkg::CS_CTRL, 8'h05);
    rxc(S, 8'h00);
    rxc(V, 8'h82);
    txb("crc", 8'h03);
    chk("guard", {31'h0, gseen >= 5}, 32'h1);
    $display("test control space done");
    rxc(S, 8'h00);
    rxc(V, 8'hE0);
    for (int i = 0; i < 8; i++) rxc(V, KEY[8*i +: 8]);
    chk("key lo", key_data[31:0], KEY[31:0]);
    chk("key hi", key_data[63:32], KEY[63:32]);
    chk("key quiet", far.q.size(), 0);
    rxc(S, 8'h00);
    rxc(V, 8'hE5);
    for (int i = 0; i < 16; i++) txb("info", INFO[8*i +: 8]);
    $display("test key and info done");
    conclude();
  end
endmodule : tb_dl_handler
